// ---- rtl/bsc_chain.sv ----
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module bsc_chain
  import bsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tck,
  input wire logic tdi,
  input wire logic chain_select,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  output logic tdo,
  output logic tdo_oe_n,
  input wire bsc_pin_s [BSC_PIN_SLOTS-1:0] pin_capture,
  input wire bsc_analog_s analog_capture,
  output bsc_pin_s [BSC_PIN_SLOTS-1:0] pin_drive,
  output bsc_analog_s analog_drive
);

  // ----------------------------------------------------------------
  // Pin synchronisation and TCK edge detection
  // ----------------------------------------------------------------
  logic [BSC_S_WIDTH-1:0] pins_async;
  logic [BSC_S_WIDTH-1:0] pins_s;
  logic tck_prev;
  logic tck_rise;
  logic tck_fall;
  logic chain_en;
  logic sel_ok;

  assign pins_async = {update_dr, shift_dr, capture_dr, chain_select, tdi, tck};

  bsc_sync #(
    .WIDTH(BSC_S_WIDTH)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in(pins_async),
    .sync_out(pins_s)
  );

  // Pin samples pass two flops too; a pin moving right at capture lands on either side, as on any scan cell.
  localparam int CAP_W = BSC_PIN_SLOTS * BSC_CELLS_PER_PIN + BSC_ANALOG_LEN;
  logic [CAP_W-1:0] cap_sync;
  bsc_pin_s [BSC_PIN_SLOTS-1:0] pin_cap_s;
  bsc_analog_s ana_cap_s;

  bsc_sync #(
    .WIDTH(CAP_W)
  ) u_cap_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in({pin_capture, analog_capture}),
    .sync_out(cap_sync)
  );

  assign {pin_cap_s, ana_cap_s} = cap_sync;

  // Remember the last synchronised TCK so both of its edges can be seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_prev <= 1'b0;
    end else if (clk_en) begin
      tck_prev <= pins_s[BSC_S_TCK];
    end
  end

  // TCK high time is about six pclk cycles, so each edge is seen exactly once.
  assign tck_rise = clk_en & pins_s[BSC_S_TCK] & ~tck_prev;
  assign tck_fall = clk_en & ~pins_s[BSC_S_TCK] & tck_prev;
  assign sel_ok = chain_en & pins_s[BSC_S_SEL];

  // ----------------------------------------------------------------
  // Parallel capture vector in chain order
  // ----------------------------------------------------------------
  logic [BSC_CHAIN_LEN-1:0] cap_vec;
  logic [BSC_CHAIN_LEN-1:0] shift_reg;
  logic [BSC_CHAIN_LEN-1:0] update_reg;

  // Each present pin lands in its slot; absent pins drive zero and capture nothing.
  for (genvar i = 0; i < BSC_PIN_SLOTS; i++) begin : g_pin
    localparam int SLOT = bsc_slot(i);
    if (SLOT >= 0) begin : g_cell
      assign cap_vec[SLOT*BSC_CELLS_PER_PIN +: BSC_CELLS_PER_PIN] = pin_cap_s[i];
      assign pin_drive[i] = update_reg[SLOT*BSC_CELLS_PER_PIN +: BSC_CELLS_PER_PIN];
    end else begin : g_none
      assign pin_drive[i] = '0;
    end
  end

  // Analog cells sit above every pin cell, the comparator group on top.
  assign cap_vec[BSC_CHAIN_LEN-1:BSC_PIN_CELLS] = ana_cap_s;
  assign analog_drive = update_reg[BSC_CHAIN_LEN-1:BSC_PIN_CELLS];

  // ----------------------------------------------------------------
  // Shift register: capture and shift on TCK rise
  // ----------------------------------------------------------------
  logic cap_evt;
  logic shift_evt;
  logic upd_evt;

  assign cap_evt = tck_rise & sel_ok & pins_s[BSC_S_CAP];
  assign shift_evt = tck_rise & sel_ok & pins_s[BSC_S_SHIFT];
  assign upd_evt = tck_fall & sel_ok & pins_s[BSC_S_UPD];

  // TDI enters at the top so bit 0, captured first, leaves first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
    end else if (cap_evt) begin
      shift_reg <= cap_vec;
    end else if (shift_evt) begin
      shift_reg <= {pins_s[BSC_S_TDI], shift_reg[BSC_CHAIN_LEN-1:1]};
    end
  end

  // ----------------------------------------------------------------
  // Update latch and TDO on TCK fall
  // ----------------------------------------------------------------
  // The update latch holds pin values steady while the next row is shifted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_reg <= '0;
    end else if (upd_evt) begin
      update_reg <= shift_reg;
    end
  end

  // TDO changes on the falling edge so the tester samples it settled on the rise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo <= shift_reg[0];
      tdo_oe_n <= ~(sel_ok & pins_s[BSC_S_SHIFT]);
    end
  end

  // ----------------------------------------------------------------
  // Shift counter for software
  // ----------------------------------------------------------------
  logic [15:0] shift_count;
  logic cnt_clr;

  // A shift in the clearing cycle still counts, so no bit is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_count <= '0;
    end else if (cap_evt) begin
      shift_count <= '0;
    end else if (shift_evt) begin
      shift_count <= cnt_clr ? 16'h0001 : shift_count + 16'h0001;
    end else if (cnt_clr) begin
      shift_count <= '0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic setup;
  logic wr_ctrl;
  logic hit;

  assign setup = psel & ~penable;
  assign hit = (paddr == BSC_OFS_CTRL) | (paddr == BSC_OFS_STATUS);
  assign wr_ctrl = clk_en & psel & penable & pready & pwrite & (paddr == BSC_OFS_CTRL);
  assign cnt_clr = wr_ctrl & pwdata[BSC_CTRL_CNT_CLR];

  // Enable gates the whole chain; with it low the scan pins are ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_en <= BSC_CTRL_ENABLE_RST;
    end else if (wr_ctrl) begin
      chain_en <= pwdata[BSC_CTRL_ENABLE];
    end
  end

  // Answers are prepared in the setup cycle, so every access ends in one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (clk_en) begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= '0;
      if (setup && !pwrite && paddr == BSC_OFS_CTRL) begin
        prdata[BSC_CTRL_ENABLE] <= chain_en;
      end else if (setup && !pwrite && paddr == BSC_OFS_STATUS) begin
        prdata[15:0] <= shift_count;
        prdata[BSC_STAT_SELECTED] <= pins_s[BSC_S_SEL];
        prdata[BSC_STAT_TDO] <= tdo;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_shift_lsb_first: assert property (@(posedge pclk) disable iff (!presetn)
    shift_evt && !cap_evt |=> shift_reg == {$past(pins_s[BSC_S_TDI]), $past(shift_reg[BSC_CHAIN_LEN-1:1])})
    else $error("chain did not shift toward bit zero");

  a_tdo_bit_zero: assert property (@(posedge pclk) disable iff (!presetn)
    tck_fall |=> tdo == $past(shift_reg[0]))
    else $error("tdo does not show chain bit zero");

  a_port_a_reversed: assert property (@(posedge pclk) disable iff (!presetn)
    cap_evt |=> shift_reg[(BSC_PORT_WIDTH-1)*BSC_CELLS_PER_PIN] == $past(pin_cap_s[0].pin_data_cell)
      && shift_reg[0] == $past(pin_cap_s[BSC_PORT_WIDTH-1].pin_data_cell))
    else $error("port a order is not reversed");

  a_analog_on_top: assert property (@(posedge pclk) disable iff (!presetn)
    cap_evt |=> shift_reg[BSC_CHAIN_LEN-1:BSC_PIN_CELLS] == $past(ana_cap_s))
    else $error("analog cells are not on top");

  a_pin_cell_order: assert property (@(posedge pclk) disable iff (!presetn)
    cap_evt |=> shift_reg[BSC_FIRST_OTHER_SLOT*BSC_CELLS_PER_PIN + BSC_CELL_DATA]
        == $past(pin_cap_s[BSC_FIRST_OTHER_SLOT].pin_data_cell)
      && shift_reg[BSC_FIRST_OTHER_SLOT*BSC_CELLS_PER_PIN + BSC_CELL_DIR]
        == $past(pin_cap_s[BSC_FIRST_OTHER_SLOT].pin_direction_cell)
      && shift_reg[BSC_FIRST_OTHER_SLOT*BSC_CELLS_PER_PIN + BSC_CELL_PULLUP]
        == $past(pin_cap_s[BSC_FIRST_OTHER_SLOT].pin_pullup_cell))
    else $error("pin cells out of order");

  a_tap_pins_skipped: assert property (@(posedge pclk) disable iff (!presetn)
    cap_evt |=> shift_reg[(BSC_PIN_CELLS/BSC_CELLS_PER_PIN - BSC_G_PINS)*BSC_CELLS_PER_PIN]
      == $past(pin_cap_s[BSC_PORT_G*BSC_PORT_WIDTH].pin_data_cell))
    else $error("port g does not follow port f bit three");

  a_cmp_top_cells: assert property (@(posedge pclk) disable iff (!presetn)
    cap_evt |=> shift_reg[BSC_POS_STANDBY] == $past(ana_cap_s.cmp.cmp_standby_cell)
      && shift_reg[BSC_POS_CMP_OUT] == $past(ana_cap_s.cmp.cmp_output_cell)
      && shift_reg[BSC_POS_MUX_USE] == $past(ana_cap_s.cmp.cmp_mux_use_cell)
      && shift_reg[BSC_POS_BANDGAP] == $past(ana_cap_s.cmp.cmp_bandgap_select))
    else $error("comparator cells misplaced");

  a_update_parallel: assert property (@(posedge pclk) disable iff (!presetn)
    upd_evt |=> update_reg == $past(shift_reg) ##1 (update_reg == $past(update_reg) || upd_evt))
    else $error("update latch lost the chain");

  // A capture loads every cell at once from the pin samples.
  a_capture_parallel: assert property (@(posedge pclk) disable iff (!presetn)
    cap_evt |=> shift_reg == $past(cap_vec))
    else $error("capture did not load all cells");

  // Between TCK rises the chain must sit still, or a slow tester would lose bits.
  a_chain_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !cap_evt && !shift_evt |=> $stable(shift_reg))
    else $error("chain moved without a tck rise");

  // The pins see only what an update delivered.
  a_update_held: assert property (@(posedge pclk) disable iff (!presetn)
    !upd_evt |=> $stable(update_reg))
    else $error("update latch moved without an update");

  // TDO and its enable move only on a TCK fall, so the tester samples a settled level.
  a_tdo_held: assert property (@(posedge pclk) disable iff (!presetn)
    !tck_fall |=> $stable(tdo) && $stable(tdo_oe_n))
    else $error("tdo moved between tck falls");

  // TDO is driven only while the chain is selected and shifting.
  a_tdo_drive_shift: assert property (@(posedge pclk) disable iff (!presetn)
    tck_fall |=> tdo_oe_n == !$past(sel_ok && pins_s[BSC_S_SHIFT]))
    else $error("tdo enable wrong for shift state");

  // With the chain off or not selected, no scan edge may touch it.
  a_disabled_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !sel_ok |=> $stable(shift_reg) && $stable(update_reg))
    else $error("chain moved while not selected");

  // Software sees one count per shifted bit.
  a_count_shifts: assert property (@(posedge pclk) disable iff (!presetn)
    shift_evt && !cap_evt && !cnt_clr |=> shift_count == $past(shift_count) + 16'h0001)
    else $error("shift count missed a bit");

endmodule
`default_nettype wire

// ---- rtl/bsc_pkg.sv ----
package bsc_pkg;

  // ----------------------------------------------------------------
  // Chain geometry
  // ----------------------------------------------------------------
  localparam int BSC_CHAIN_LEN = 198;
  localparam int BSC_PIN_SLOTS = 56;
  localparam int BSC_PORT_WIDTH = 8;
  localparam int BSC_CELLS_PER_PIN = 3;
  localparam int BSC_PIN_CELLS = 150;
  localparam int BSC_ANALOG_LEN = 48;
  localparam int BSC_ANALOG_MISC = 44;
  localparam int BSC_PORT_A = 0;
  localparam int BSC_PORT_F = 5;
  localparam int BSC_PORT_G = 6;
  localparam int BSC_F_TAP_FIRST = 4;
  localparam int BSC_G_PINS = 6;
  localparam int BSC_FIRST_OTHER_SLOT = 8;

  // Cell position inside one pin group, and the named top cells.
  localparam int BSC_CELL_DATA = 0;
  localparam int BSC_CELL_DIR = 1;
  localparam int BSC_CELL_PULLUP = 2;
  localparam int BSC_POS_STANDBY = 197;
  localparam int BSC_POS_CMP_OUT = 196;
  localparam int BSC_POS_MUX_USE = 195;
  localparam int BSC_POS_BANDGAP = 194;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] BSC_OFS_CTRL = 12'h000;
  localparam logic [11:0] BSC_OFS_STATUS = 12'h004;
  localparam int BSC_CTRL_ENABLE = 0;
  localparam int BSC_CTRL_CNT_CLR = 1;
  localparam int BSC_STAT_SELECTED = 16;
  localparam int BSC_STAT_TDO = 17;
  localparam logic BSC_CTRL_ENABLE_RST = 1'b1;
  localparam int BSC_SYNC_STAGES = 2;

  // Index of each synchronised pin in the sync vector.
  localparam int BSC_S_TCK = 0;
  localparam int BSC_S_TDI = 1;
  localparam int BSC_S_SEL = 2;
  localparam int BSC_S_CAP = 3;
  localparam int BSC_S_SHIFT = 4;
  localparam int BSC_S_UPD = 5;
  localparam int BSC_S_WIDTH = 6;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Data sits in the lowest bit so a pin group drops straight into the chain.
  typedef struct packed {
    logic pin_pullup_cell;
    logic pin_direction_cell;
    logic pin_data_cell;
  } bsc_pin_s;

  typedef struct packed {
    logic cmp_standby_cell;
    logic cmp_output_cell;
    logic cmp_mux_use_cell;
    logic cmp_bandgap_select;
  } bsc_cmp_s;

  typedef struct packed {
    bsc_cmp_s cmp;
    logic [BSC_ANALOG_MISC-1:0] misc;
  } bsc_analog_s;

  // Port F upper half and the missing port G pins have no cells.
  function automatic bit bsc_pin_valid(input int idx);
    int port;
    int pbit;
    port = idx / BSC_PORT_WIDTH;
    pbit = idx % BSC_PORT_WIDTH;
    if (port == BSC_PORT_F && pbit >= BSC_F_TAP_FIRST) return 1'b0;
    if (port == BSC_PORT_G && pbit >= BSC_G_PINS) return 1'b0;
    return 1'b1;
  endfunction

  // Chain slot of a pin; port A runs backwards, the rest upwards; -1 when absent.
  function automatic int bsc_slot(input int idx);
    int slot;
    slot = BSC_FIRST_OTHER_SLOT;
    if (!bsc_pin_valid(idx)) return -1;
    if (idx / BSC_PORT_WIDTH == BSC_PORT_A) return BSC_PORT_WIDTH - 1 - idx;
    for (int j = BSC_FIRST_OTHER_SLOT; j < idx; j++) begin
      if (bsc_pin_valid(j)) slot++;
    end
    return slot;
  endfunction

endpackage

// ---- rtl/bsc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module bsc_sync
  import bsc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second, so a metastable level never fans out.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// ---- testbench/bsc_tester.sv ----
`timescale 1ns/10ps
`default_nettype none

module bsc_tester (
  input wire logic pclk,
  output logic tck,
  output logic tdi,
  output logic chain_select,
  output logic capture_dr,
  output logic shift_dr,
  output logic update_dr,
  input wire logic tdo
);
  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  // A 125 ns TCK keeps four held rows well inside the hold limit.
  localparam realtime HALF = 62.5;

  // All pins start low; TCK stands still between frames.
  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    chain_select = 1'b0;
    capture_dr = 1'b0;
    shift_dr = 1'b0;
    update_dr = 1'b0;
  end

  // One full data-register frame: capture, 198 shifts, update.
  // Preload and external-test both select this chain, so one frame form serves every row.
  task automatic scan(input logic [197:0] din, output logic [197:0] dout);
    // Start just after a system edge so no pin ever moves on a sampling edge.
    @(posedge pclk);
    #1;
    chain_select = 1'b1;
    capture_dr = 1'b1;
    #HALF tck = 1'b1;
    #HALF tck = 1'b0;
    capture_dr = 1'b0;
    shift_dr = 1'b1;
    for (int i = 0; i < 198; i++) begin
      tdi = din[i];
      #HALF dout[i] = tdo;
      tck = 1'b1;
      #HALF tck = 1'b0;
    end
    shift_dr = 1'b0;
    update_dr = 1'b1;
    // Released data line shows the inverse of its last value.
    tdi = ~din[197];
    #HALF tck = 1'b1;
    #HALF tck = 1'b0;
    update_dr = 1'b0;
    #HALF;
  endtask
endmodule

`default_nettype wire

// ---- testbench/boundary_scan_adc_test_chain_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module boundary_scan_adc_test_chain_tb
  import bsc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic tck, tdi, chain_select, capture_dr, shift_dr, update_dr, tdo, tdo_oe_n;
  bsc_pin_s [BSC_PIN_SLOTS-1:0] pin_capture, pin_drive;
  bsc_analog_s analog_capture, analog_drive;
  int err_total, n_compared;
  // Converter cell places inside the analog misc field are assumed.
  localparam int POS_EN = 150;
  localparam int POS_DAC = 151;
  localparam int POS_MUX = 161;
  localparam int POS_HOLD = 169;
  localparam int POS_LATCH = 170;

  bsc_chain uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tck(tck), .tdi(tdi), .chain_select(chain_select), .capture_dr(capture_dr),
    .shift_dr(shift_dr), .update_dr(update_dr), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .pin_capture(pin_capture), .analog_capture(analog_capture), .pin_drive(pin_drive),
    .analog_drive(analog_drive));

  bsc_tester tst (.pclk(pclk), .tck(tck), .tdi(tdi), .chain_select(chain_select), .capture_dr(capture_dr),
    .shift_dr(shift_dr), .update_dr(update_dr), .tdo(tdo));

  // Free-running system clock.
  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [197:0] got, input logic [197:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // Chain slot of a pin, or -1 for pins that carry no cells.
  function automatic int slot_of(input int i);
    int s;
    s = 8;
    if (i / 8 == 5 && i % 8 >= 4) return -1;
    if (i / 8 == 6 && i % 8 >= 6) return -1;
    if (i < 8) return 7 - i;
    // Count present pins directly; asking slot_of for each would take exponential time.
    for (int j = 8; j < i; j++) begin
      if (!(j / 8 == 5 && j % 8 >= 4) && !(j / 8 == 6 && j % 8 >= 6)) s++;
    end
    return s;
  endfunction

  function automatic logic [197:0] exp_cap();
    logic [197:0] v;
    int s;
    v = '0;
    for (int i = 0; i < BSC_PIN_SLOTS; i++) begin
      s = slot_of(i);
      if (s >= 0) v[3*s +: 3] = pin_capture[i];
    end
    v[197:150] = analog_capture;
    return v;
  endfunction

  // Converter row; channel pin cells stay 0, enable 1, select 0x08.
  function automatic logic [197:0] adc_row(input logic [9:0] dac, input logic hold, input logic lrn);
    logic [197:0] v;
    v = '0;
    v[POS_EN] = 1'b1;
    v[POS_DAC +: 10] = dac;
    v[POS_MUX +: 8] = 8'h08;
    v[POS_HOLD] = hold;
    v[POS_LATCH] = lrn;
    return v;
  endfunction

  // Holds every request until pready is sampled high, giving up after 20 cycles.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(1'b0, 1'b1, "bus wait");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    chk(tdo_oe_n, 1'b1, "oe in reset");
    chk(pin_drive, '0, "drive in reset");
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, BSC_OFS_CTRL, 32'h0, r, e);
    chk({e, r}, 33'h0_0000_0001, "ctrl reset");
    apb(1'b1, BSC_OFS_STATUS, 32'hFFFF_FFFF, r, e);
    chk(e, 1'b0, "status write");
    apb(1'b0, BSC_OFS_STATUS, 32'h0, r, e);
    chk({e, r}, 33'h0, "status reset");
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk({e, r}, {1'b1, 32'h0}, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_order();
    logic [197:0] row, got;
    logic [31:0] r;
    logic e;
    int s;
    for (int i = 0; i < BSC_PIN_SLOTS; i++) pin_capture[i] <= 3'(i + 3 * (i >> 3));
    analog_capture <= 48'hA5C3_0F1E_9B27;
    row = {6{33'h1_2345_6789}};
    @(posedge pclk);
    tst.scan(row, got);
    chk(got, exp_cap(), "captured chain");
    chk(got[197:194], analog_capture.cmp, "top cells");
    for (int i = 0; i < BSC_PIN_SLOTS; i++) begin
      s = slot_of(i);
      if (s >= 0) chk(pin_drive[i], row[3*s +: 3], "pin drive");
      else chk(pin_drive[i], 3'b000, "absent pin");
    end
    chk(analog_drive, row[197:150], "analog drive");
    apb(1'b0, BSC_OFS_STATUS, 32'h0, r, e);
    chk(r[17:0], {row[0], 1'b1, 16'd198}, "shift count");
    $display("test order done");
  endtask

  task automatic t_adc();
    logic [197:0] got;
    logic [9:0] lim;
    tst.scan(adc_row(10'h200, 1'b1, 1'b1), got);
    for (int k = 0; k < 2; k++) begin
      lim = k ? 10'h143 : 10'h123;
      tst.scan(adc_row(10'h200, 1'b0, 1'b1), got);
      tst.scan(adc_row(10'h200, 1'b1, 1'b1), got);
      tst.scan(adc_row(lim, 1'b1, 1'b1), got);
      tst.scan(adc_row(lim, 1'b1, 1'b0), got);
      chk(analog_drive[POS_DAC-150 +: 10], lim, "dac drive");
      // The comparator reports low for the lower limit, high for the upper.
      @(posedge pclk);
      analog_capture.misc[BSC_ANALOG_MISC-1] <= k[0];
      tst.scan(adc_row(10'h200, 1'b1, 1'b1), got);
      chk(got[BSC_POS_BANDGAP-1], k[0], "comparator result");
    end
    chk(pin_drive[3], 3'b000, "channel pin");
    chk(analog_drive[POS_MUX-150 +: 8], 8'h08, "input select");
    $display("test converter done");
  endtask

  task automatic t_refuse();
    logic [197:0] got;
    logic [167:0] prev;
    logic [31:0] r;
    logic e;
    apb(1'b1, BSC_OFS_CTRL, 32'h3, r, e);
    apb(1'b1, BSC_OFS_CTRL, 32'h0, r, e);
    prev = pin_drive;
    tst.scan('1, got);
    chk(pin_drive, prev, "disabled drive");
    // A frozen chain keeps showing bit 0 of the last converter row, which is 0.
    chk(got, '0, "disabled shift");
    chk(tdo_oe_n, 1'b1, "disabled oe");
    apb(1'b0, BSC_OFS_STATUS, 32'h0, r, e);
    chk(r[15:0], 16'h0000, "disabled count");
    apb(1'b1, BSC_OFS_CTRL, 32'h1, r, e);
    $display("test refuse done");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence; reset is held for two clock cycles.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pin_capture = '0;
    analog_capture = '0;
    err_total = 0;
    n_compared = 0;
    repeat (2) @(posedge pclk);
    t_reset();
    t_order();
    t_adc();
    t_refuse();
    stop_test();
  end

  // Thirteen frames take about 0.33 ms; a hang is cut off at 0.6 ms.
  initial begin
    #600000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule

`default_nettype wire
